/* core/rcdsw_pkg.sv */
// package of constants for the radio core deep sleep wake-up timer
package rcdsw_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_WAKE_TIMING   = 8'h00;
	localparam logic [7:0] OFF_SLEEP_LENGTH  = 8'h04;
	localparam logic [7:0] OFF_SLEEP_CONTROL = 8'h08;
	localparam logic [7:0] OFF_SLEEP_ELAPSED = 8'h0C;
	localparam logic [7:0] OFF_GENERAL_CTRL  = 8'h10;
	localparam logic [7:0] OFF_LINK_STATUS   = 8'h14;
	localparam logic [7:0] OFF_EXCH_MEM_BASE = 8'h18;
	localparam logic [7:0] OFF_CLOCK_CFG     = 8'h1C;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int WT_LEAD_LSB    = 0;
	localparam int WT_RELEASE_LSB = 10;
	localparam int WT_EXT_LSB     = 20;
	localparam int WT_FIELD_W     = 10;
	localparam int SC_SLEEP_GO    = 0;
	localparam int SC_EXT_BLOCK   = 1;
	localparam int GC_WAKE_REQ    = 0;
	localparam int GC_CLK_GATE    = 1;
	localparam int GC_RADIO_SLEEP = 2;
	localparam int LS_PWRDN_OK    = 0;
	localparam int LS_ASLEEP      = 1;
	localparam int LS_WAKE_IRQ    = 2;
	localparam int LS_EXIT_IRQ    = 3;
	localparam int CC_LP_SEL_LSB  = 0;
	localparam int CC_FAST_8M     = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] RST_WAKE_TIMING = 32'h0000_0000;
	localparam logic [31:0] RST_EXCH_BASE   = 32'h0000_0000;
	localparam logic [31:0] RST_GENERAL     = 32'h0000_0002;

	// ****************************************************************
	// low-power tick choices and slot timing
	// ****************************************************************
	localparam logic [1:0] LP_SEL_15K    = 2'h0;
	localparam logic [1:0] LP_SEL_32K0   = 2'h1;
	localparam logic [1:0] LP_SEL_32K768 = 2'h2;
	localparam int SLOT_US          = 625;
	localparam int CLK_HZ           = 20_000_000;
	// tick generator phase increments, 32-bit accumulator: inc = f * 2^32 / CLK_HZ
	localparam logic [31:0] INC_15K    = 32'(64'(15_000) * 64'h1_0000_0000 / 64'(CLK_HZ));
	localparam logic [31:0] INC_32K0   = 32'(64'(32_000) * 64'h1_0000_0000 / 64'(CLK_HZ));
	localparam logic [31:0] INC_32K768 = 32'(64'(32_768) * 64'h1_0000_0000 / 64'(CLK_HZ));
	// slot length in ticks per tick rate (625 us times frequency, whole ticks)
	localparam logic [4:0] SLOT_T_15K    = 5'(15_000 * SLOT_US / 1_000_000);
	localparam logic [4:0] SLOT_T_32K0   = 5'(32_000 * SLOT_US / 1_000_000);
	localparam logic [4:0] SLOT_T_32K768 = 5'(32_768 * SLOT_US / 1_000_000);

	// ****************************************************************
	// AXI response codes
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rcdsw_pkg

/* core/rcdsw_tick_gen.sv */
// low-power tick enable generator from the fast clock
`timescale 1ns/10ps
`default_nettype none
module rcdsw_tick_gen (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] lp_sel,
	output logic            tick
);

	typedef struct packed {
		logic [31:0] acc;
		logic        tick;
	} rcdsw_tg_t;

	rcdsw_tg_t st_reg;
	rcdsw_tg_t st_next;
	logic [32:0] sum;
	logic [31:0] inc;

	// ****************************************************************
	// phase accumulator
	// ****************************************************************
	always_comb begin
		case (lp_sel)
			rcdsw_pkg::LP_SEL_32K0:   inc = rcdsw_pkg::INC_32K0;
			rcdsw_pkg::LP_SEL_32K768: inc = rcdsw_pkg::INC_32K768;
			default:                  inc = rcdsw_pkg::INC_15K;
		endcase
		sum          = {1'b0, st_reg.acc} + {1'b0, inc};
		st_next.acc  = sum[31:0];
		st_next.tick = sum[32];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

endmodule : rcdsw_tick_gen
`default_nettype wire

/* core/rcdsw_sleep_timer.sv */
// deep sleep timer, wake interrupt sequencing and AXI4-Lite registers
//
// Summary of operation
// RULE1: exit raises the low-power wake interrupt first, then the sleep-exit interrupt.
// RULE2: the same two-interrupt order applies to timer expiry and software wake.
// RULE3: wake interrupt rises wake-lead ticks before the sleep timer expires.
// RULE4: software keeps wake-lead above trim plus handler time, else sleep lengthens.
// RULE5: wake interrupt falls wake-release ticks before the sleep period ends.
// RULE6: on software wake, wake interrupt high time follows the external-wake pulse field; the code uses that field minus wake-release.
// RULE7: writing 1 to the software wake request raises the wake interrupt at once.
// RULE8: software programs sleep duration at least wake-lead plus one ticks.
// RULE9: software programs timing fields, then duration, then sets sleep-go.
// RULE10: in deep sleep base timing runs on the tick, keeping the 625 us slot; the code uses whole ticks, 600 us at 15 kHz, about 610 us at 32.768 kHz.
// RULE11: power-down-permitted flag rises once the switch into deep sleep completes.
// RULE12: software stops the fast clocks via the clock gate bit after the switch.
// RULE13: software may then power off the radio domain via the radio sleep bit.
// RULE14: the low-power tick is 15 kHz, 32.0 kHz or 32.768 kHz.
// RULE15: the active main clock is 16 MHz or 8 MHz; the code assumes CLK_HZ of 20 MHz and only stores the fast_8m bit.
// RULE16: exchange memory base address sits in a programmable register.
// RULE17: after expiry stay asleep until core powered, report the real sleep length.
// RULE18: while the software wake request is high, sleep entry is refused.
// RULE19: software wake requests are ignored while the external-wake block bit is set.
// RULE20: the timer counts ticks from sleep-go and compares against the duration.
`timescale 1ns/10ps
`default_nettype none
module rcdsw_sleep_timer #(
	parameter int DUR_W = 32
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        core_powered,
	output logic             lp_wake_irq,
	output logic             sleep_exit_irq,
	output logic             radio_off_permitted,
	output logic             core_clock_enable,
	output logic             radio_domain_sleep,
	output logic             slot_strobe,
	output logic [31:0]      exchange_mem_base
);

	// elaboration-time refusal of widths the field views cannot serve
	if (DUR_W < 12 || DUR_W > 32) begin : g_bad_dur_w
		$error("DUR_W must lie in 12..32");
	end

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_SLEEP  = 4'h2,
		ST_HOLD   = 4'h4,
		ST_EXIT   = 4'h8
	} rcdsw_state_t;

	typedef struct packed {
		rcdsw_state_t state;
		logic [31:0]  wake_timing_reg;
		logic [DUR_W-1:0] sleep_length_reg;
		logic [DUR_W-1:0] sleep_elapsed_reg;
		logic         sleep_go;
		logic         ext_wake_block;
		logic         sw_wake_request;
		logic         clk_gate;
		logic         radio_sleep;
		logic [1:0]   lp_sel;
		logic         fast_8m;
		logic [31:0]  exch_base;
		logic [DUR_W-1:0] count;
		logic [DUR_W-1:0] ext_count;
		logic         ext_wake;
		logic         wake_irq;
		logic         exit_irq;
		logic         pwrdn_ok;
		logic [4:0]   slot_cnt;
		logic         slot;
		logic         pwr_s1;
		logic         pwr_s2;
		logic         aw_got;
		logic         w_got;
		logic [7:0]   aw_addr;
		logic [31:0]  w_data;
		logic [3:0]   w_strb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
	} rcdsw_st_t;

	rcdsw_st_t st_reg;
	rcdsw_st_t st_next;
	logic      tick;

	rcdsw_tick_gen u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lp_sel  (st_reg.lp_sel),
		.tick    (tick)
	);

	// field views
	logic [DUR_W-1:0] lead_cnt;
	logic [DUR_W-1:0] release_cnt;
	logic [DUR_W-1:0] ext_len;
	logic [DUR_W-1:0] remain;
	logic [4:0]       slot_len;
	logic [31:0]      wr_merged;
	logic [31:0]      rd_word;
	logic             rd_ok;
	logic             wr_ok;

	assign lead_cnt    = DUR_W'(st_reg.wake_timing_reg[rcdsw_pkg::WT_LEAD_LSB +: 10]);
	assign release_cnt = DUR_W'(st_reg.wake_timing_reg[rcdsw_pkg::WT_RELEASE_LSB +: 10]);
	assign ext_len     = DUR_W'(st_reg.wake_timing_reg[rcdsw_pkg::WT_EXT_LSB +: 10]);
	assign remain      = st_reg.sleep_length_reg - st_reg.count;

	always_comb begin
		case (st_reg.lp_sel)
			rcdsw_pkg::LP_SEL_32K0:   slot_len = rcdsw_pkg::SLOT_T_32K0;
			rcdsw_pkg::LP_SEL_32K768: slot_len = rcdsw_pkg::SLOT_T_32K768;
			default:                  slot_len = rcdsw_pkg::SLOT_T_15K;
		endcase
	end

	// ****************************************************************
	// register read mux
	// ****************************************************************
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr[7:0])
			rcdsw_pkg::OFF_WAKE_TIMING:   rd_word = st_reg.wake_timing_reg;
			rcdsw_pkg::OFF_SLEEP_LENGTH:  rd_word = 32'(st_reg.sleep_length_reg);
			rcdsw_pkg::OFF_SLEEP_CONTROL: begin
				rd_word[rcdsw_pkg::SC_SLEEP_GO]  = st_reg.sleep_go;
				rd_word[rcdsw_pkg::SC_EXT_BLOCK] = st_reg.ext_wake_block;
			end
			rcdsw_pkg::OFF_SLEEP_ELAPSED: rd_word = 32'(st_reg.sleep_elapsed_reg); // [RULE17]
			rcdsw_pkg::OFF_GENERAL_CTRL:  begin
				rd_word[rcdsw_pkg::GC_WAKE_REQ]    = st_reg.sw_wake_request;
				rd_word[rcdsw_pkg::GC_CLK_GATE]    = st_reg.clk_gate;
				rd_word[rcdsw_pkg::GC_RADIO_SLEEP] = st_reg.radio_sleep;
			end
			rcdsw_pkg::OFF_LINK_STATUS:   begin
				rd_word[rcdsw_pkg::LS_PWRDN_OK] = st_reg.pwrdn_ok; // [RULE11]
				rd_word[rcdsw_pkg::LS_ASLEEP]   = (st_reg.state != ST_ACTIVE);
				rd_word[rcdsw_pkg::LS_WAKE_IRQ] = st_reg.wake_irq;
				rd_word[rcdsw_pkg::LS_EXIT_IRQ] = st_reg.exit_irq;
			end
			rcdsw_pkg::OFF_EXCH_MEM_BASE: rd_word = st_reg.exch_base; // [RULE16]
			rcdsw_pkg::OFF_CLOCK_CFG:     begin
				rd_word[rcdsw_pkg::CC_LP_SEL_LSB +: 2] = st_reg.lp_sel;
				rd_word[rcdsw_pkg::CC_FAST_8M]         = st_reg.fast_8m;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr_merged[i*8 +: 8] = st_reg.w_strb[i] ? st_reg.w_data[i*8 +: 8] : 8'h00;
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic do_write;
		logic wake_set;
		do_write = 1'b0;
		wake_set = 1'b0;
		wr_ok    = 1'b1;
		st_next  = st_reg;

		st_next.pwr_s1 = core_powered;
		st_next.pwr_s2 = st_reg.pwr_s1;
		st_next.exit_irq = 1'b0;
		st_next.slot     = 1'b0;

		// write channel capture, either order
		if (s_axi_awvalid && !st_reg.aw_got) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !st_reg.w_got) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			do_write        = 1'b1;
			st_next.aw_got  = 1'b0;
			st_next.w_got   = 1'b0;
			st_next.bvalid  = 1'b1;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		if (do_write) begin
			case (st_reg.aw_addr)
				rcdsw_pkg::OFF_WAKE_TIMING:   st_next.wake_timing_reg = wr_merged;
				rcdsw_pkg::OFF_SLEEP_LENGTH:  st_next.sleep_length_reg = DUR_W'(wr_merged);
				rcdsw_pkg::OFF_SLEEP_CONTROL: begin
					st_next.ext_wake_block = wr_merged[rcdsw_pkg::SC_EXT_BLOCK];
					// entry refused while a wake request is pending
					if (wr_merged[rcdsw_pkg::SC_SLEEP_GO] && st_reg.state == ST_ACTIVE
						&& !st_reg.sw_wake_request) begin // [RULE18]
						st_next.sleep_go = 1'b1;
						st_next.state    = ST_SLEEP;
						st_next.count    = '0; // [RULE20]
						st_next.slot_cnt = '0;
					end
				end
				rcdsw_pkg::OFF_GENERAL_CTRL:  begin
					st_next.sw_wake_request = wr_merged[rcdsw_pkg::GC_WAKE_REQ];
					st_next.clk_gate        = wr_merged[rcdsw_pkg::GC_CLK_GATE];
					st_next.radio_sleep     = wr_merged[rcdsw_pkg::GC_RADIO_SLEEP];
					wake_set = wr_merged[rcdsw_pkg::GC_WAKE_REQ] && !st_reg.ext_wake_block; // [RULE19]
				end
				rcdsw_pkg::OFF_EXCH_MEM_BASE: st_next.exch_base = wr_merged; // [RULE16]
				rcdsw_pkg::OFF_CLOCK_CFG:     begin
					st_next.lp_sel  = wr_merged[rcdsw_pkg::CC_LP_SEL_LSB +: 2];
					st_next.fast_8m = wr_merged[rcdsw_pkg::CC_FAST_8M]; // [RULE15]
					// only three tick rates exist
					if (st_next.lp_sel == 2'h3) st_next.lp_sel = rcdsw_pkg::LP_SEL_32K768; // [RULE14]
				end
				rcdsw_pkg::OFF_SLEEP_ELAPSED,
				rcdsw_pkg::OFF_LINK_STATUS:   ;
				default: wr_ok = 1'b0;
			endcase
			st_next.bresp = wr_ok ? rcdsw_pkg::RESP_OKAY : rcdsw_pkg::RESP_SLVERR;
		end

		// read channel
		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_word;
			st_next.rresp  = rd_ok ? rcdsw_pkg::RESP_OKAY : rcdsw_pkg::RESP_SLVERR;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		case (st_reg.state)
			ST_ACTIVE: begin
				st_next.pwrdn_ok = 1'b0;
			end
			ST_SLEEP, ST_HOLD: begin
				// switch to tick timing completed: permit power down
				st_next.pwrdn_ok = 1'b1; // [RULE11]
				if (tick) begin
					// slot reference on the tick, 625 us rounded down to whole ticks
					if (st_reg.slot_cnt + 5'h01 >= slot_len) begin // [RULE10]
						st_next.slot_cnt = '0;
						st_next.slot     = 1'b1;
					end else begin
						st_next.slot_cnt = st_reg.slot_cnt + 5'h01;
					end
					st_next.sleep_elapsed_reg = st_reg.count + 1'b1; // [RULE17]
					if (st_reg.ext_wake) begin
						// high time of the forced pulse set by the external-wake field minus the wake-release field
						st_next.ext_count = st_reg.ext_count + 1'b1;
						if (st_reg.ext_count + 1'b1 >= ext_len - release_cnt) begin // [RULE6]
							st_next.wake_irq = 1'b0;
						end
					end
					if (!st_reg.ext_wake && st_reg.state == ST_SLEEP) begin
						st_next.count = st_reg.count + 1'b1; // [RULE20]
						if (remain - 1'b1 == lead_cnt) st_next.wake_irq = 1'b1; // [RULE3]
						if (remain - 1'b1 == release_cnt) st_next.wake_irq = 1'b0; // [RULE5]
						if (remain <= DUR_W'(1)) st_next.state = ST_HOLD;
					end else if (st_reg.state == ST_HOLD) begin
						st_next.count = st_reg.count + 1'b1;
					end
				end
				// exit only after the wake irq pulse has ended and the core is up
				if ((st_reg.state == ST_HOLD || (st_reg.ext_wake && !st_reg.wake_irq))
					&& !st_reg.wake_irq && st_reg.pwr_s2 && st_reg.clk_gate) begin // [RULE1]
					st_next.state = ST_EXIT; // [RULE2]
				end
			end
			ST_EXIT: begin
				st_next.exit_irq = 1'b1; // [RULE1]
				st_next.sleep_go = 1'b0;
				st_next.ext_wake = 1'b0;
				st_next.pwrdn_ok = 1'b0;
				st_next.state    = ST_ACTIVE;
			end
			default: st_next.state = ST_ACTIVE;
		endcase

		// software wake while asleep: timer stops, wake irq rises at once
		// placed last so the set wins over a timer release in the same tick
		if (wake_set && (st_reg.state == ST_SLEEP || st_reg.state == ST_HOLD)
			&& !st_reg.ext_wake && st_next.state != ST_EXIT) begin
			st_next.ext_wake  = 1'b1;
			st_next.wake_irq  = 1'b1; // [RULE7]
			st_next.ext_count = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg                 <= '0;
			st_reg.state           <= ST_ACTIVE;
			st_reg.wake_timing_reg <= rcdsw_pkg::RST_WAKE_TIMING;
			st_reg.exch_base       <= rcdsw_pkg::RST_EXCH_BASE;
			st_reg.clk_gate        <= rcdsw_pkg::RST_GENERAL[rcdsw_pkg::GC_CLK_GATE];
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign s_axi_awready       = !st_reg.aw_got;
	assign s_axi_wready        = !st_reg.w_got;
	assign s_axi_bvalid        = st_reg.bvalid;
	assign s_axi_bresp         = st_reg.bresp;
	assign s_axi_arready       = !st_reg.rvalid;
	assign s_axi_rvalid        = st_reg.rvalid;
	assign s_axi_rdata         = st_reg.rdata;
	assign s_axi_rresp         = st_reg.rresp;
	assign lp_wake_irq         = st_reg.wake_irq;
	assign sleep_exit_irq      = st_reg.exit_irq;
	assign radio_off_permitted = st_reg.pwrdn_ok;
	assign core_clock_enable   = st_reg.clk_gate;
	assign radio_domain_sleep  = st_reg.radio_sleep;
	assign slot_strobe         = st_reg.slot;
	assign exchange_mem_base   = st_reg.exch_base;

endmodule : rcdsw_sleep_timer
`default_nettype wire

/* tb/rcdsw_sleep_checker.sv */
// concurrent checks on the sleep timer ports
`timescale 1ns/10ps
`default_nettype none
module rcdsw_sleep_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        core_powered,
	input wire logic        lp_wake_irq,
	input wire logic        sleep_exit_irq,
	input wire logic        radio_off_permitted,
	input wire logic        core_clock_enable,
	input wire logic        radio_domain_sleep,
	input wire logic        slot_strobe,
	input wire logic [31:0] exchange_mem_base
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************************************
	// assertions
	// ****************************************************************
	exit_order_a: assert property (sleep_exit_irq |-> !lp_wake_irq)
		else $error("exit pulse while wake interrupt high");
	exit_pulse_a: assert property (sleep_exit_irq |=> !sleep_exit_irq)
		else $error("exit pulse longer than one cycle");
	exit_gap_a: assert property ($fell(lp_wake_irq) |-> !sleep_exit_irq ##1 !sleep_exit_irq)
		else $error("exit pulse too close to wake fall");
	exit_power_a: assert property (sleep_exit_irq |-> $past(core_powered, 4) && $past(core_clock_enable, 2))
		else $error("exit without power or clocks");
	wake_asleep_a: assert property (lp_wake_irq |-> radio_off_permitted)
		else $error("wake interrupt outside sleep");
	slot_asleep_a: assert property (slot_strobe |-> radio_off_permitted || $past(radio_off_permitted))
		else $error("slot strobe outside sleep");
	permit_hold_a: assert property ($rose(radio_off_permitted) |=> radio_off_permitted [*4])
		else $error("power-down flag dropped early");
	reg_update_a: assert property ($changed(core_clock_enable) || $changed(radio_domain_sleep)
		|| $changed(exchange_mem_base) |-> s_axi_bvalid)
		else $error("control output moved without a write");

	cover property (sleep_exit_irq);
	cover property ($rose(lp_wake_irq));
	cover property (slot_strobe);
endmodule : rcdsw_sleep_checker

bind rcdsw_sleep_timer rcdsw_sleep_checker u_chk (.aclk, .aresetn, .s_axi_bvalid, .core_powered,
	.lp_wake_irq, .sleep_exit_irq, .radio_off_permitted, .core_clock_enable,
	.radio_domain_sleep, .slot_strobe, .exchange_mem_base);
`default_nettype wire

/* tb/rcdsw_power_model.sv */
// power unit model driving the core power-good level
`timescale 1ns/10ps
`default_nettype none
module rcdsw_power_model #(
	parameter int UP_DELAY = 40
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic radio_domain_sleep,
	output logic     core_powered
);
	int up_cnt;

	// domain drops at once, returns after a ramp delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_cnt <= UP_DELAY;
			core_powered <= 1'b1;
		end else if (radio_domain_sleep) begin
			up_cnt <= 0;
			core_powered <= 1'b0;
		end else if (up_cnt < UP_DELAY) begin
			up_cnt <= up_cnt + 1;
		end else begin
			core_powered <= 1'b1;
		end
	end
endmodule : rcdsw_power_model
`default_nettype wire

/* tb/radio_core_deep_sleep_wakeup_tb.sv */
// testbench for the deep sleep wake-up timer
`timescale 1ns/10ps
`default_nettype none
module radio_core_deep_sleep_wakeup_tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, core_powered, lp_wake_irq, sleep_exit_irq;
	logic        radio_off_permitted, core_clock_enable, radio_domain_sleep, slot_strobe;
	logic        wake_prev;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, exchange_mem_base, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
	int          mismatches, cmp_count, wake_w, exit_n, slot_n, slot_gap, slot_last, cyc;
	int          e0, s0, p, g;
	int          fr[3] = '{15000, 32000, 32768};

	rcdsw_sleep_timer #(.DUR_W(32)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.core_powered, .lp_wake_irq, .sleep_exit_irq, .radio_off_permitted,
		.core_clock_enable, .radio_domain_sleep, .slot_strobe, .exchange_mem_base);
	rcdsw_power_model #(.UP_DELAY(40)) u_pmu (.aclk, .aresetn, .radio_domain_sleep,
		.core_powered);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ****************************************************************
	// port monitor
	// ****************************************************************
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		wake_prev <= lp_wake_irq;
		if (lp_wake_irq) wake_w <= wake_prev ? wake_w + 1 : 1;
		if (sleep_exit_irq) exit_n <= exit_n + 1;
		if (slot_strobe) begin
			slot_gap <= cyc - slot_last;
			slot_last <= cyc;
			slot_n <= slot_n + 1;
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic in_range(input int v, input int lo, input int hi);
		check(32'(v >= lo && v <= hi), 32'h1);
	endtask : in_range

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		bs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read

	// program timing, duration, then sleep-go; then gate clocks and radio
	task automatic do_sleep(input logic [1:0] sel, input logic [9:0] lead, input logic [9:0] rel,
		input logic [9:0] ext, input logic [31:0] dur, input logic [1:0] ctl);
		axi_write(rcdsw_pkg::OFF_CLOCK_CFG, {30'h0, sel});
		axi_write(rcdsw_pkg::OFF_WAKE_TIMING, {2'h0, ext, rel, lead});
		axi_write(rcdsw_pkg::OFF_SLEEP_LENGTH, dur);
		axi_write(rcdsw_pkg::OFF_SLEEP_CONTROL, {30'h0, ctl});
		wait (radio_off_permitted);
		@(posedge aclk);
		axi_read(rcdsw_pkg::OFF_LINK_STATUS, rd, rs);
		check({31'h0, rd[rcdsw_pkg::LS_PWRDN_OK]}, 32'h1);
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0004);
		check({30'h0, core_clock_enable, radio_domain_sleep}, 32'h1);
	endtask : do_sleep

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (95000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		{mismatches, cmp_count, wake_w, exit_n, slot_n, slot_gap, slot_last, cyc} = '0;
		wake_prev = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_read(rcdsw_pkg::OFF_GENERAL_CTRL, rd, rs);
		check(rd, rcdsw_pkg::RST_GENERAL);
		axi_read(rcdsw_pkg::OFF_WAKE_TIMING, rd, rs);
		check(rd, rcdsw_pkg::RST_WAKE_TIMING);
		axi_read(8'h20, rd, rs);
		check({rd[29:0], rs}, {30'h0, rcdsw_pkg::RESP_SLVERR});
		axi_write(rcdsw_pkg::OFF_EXCH_MEM_BASE, 32'hA5A5_1230);
		check(exchange_mem_base, 32'hA5A5_1230);
		check({30'h0, bs}, {30'h0, rcdsw_pkg::RESP_OKAY});
		axi_write(8'h20, 32'h0000_0001);
		check({30'h0, bs}, {30'h0, rcdsw_pkg::RESP_SLVERR});
		axi_write(rcdsw_pkg::OFF_CLOCK_CFG, 32'h0000_0007);
		axi_read(rcdsw_pkg::OFF_CLOCK_CFG, rd, rs);
		check(rd, 32'h0000_0006);
		for (int i = 0; i < 3; i++) begin
			p = rcdsw_pkg::CLK_HZ / fr[i];
			do_sleep(2'(i), 10'h3, 10'h1, 10'h2, 32'h5, 2'h1);
			e0 = exit_n;
			wait (lp_wake_irq);
			check(exit_n, e0);
			wait (!lp_wake_irq);
			@(posedge aclk);
			in_range(wake_w, 2 * p - 2, 2 * p + 4);
			repeat (3 * p) @(posedge aclk);
			check(exit_n, e0);
			axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0002);
			wait (exit_n != e0);
			axi_read(rcdsw_pkg::OFF_SLEEP_ELAPSED, rd, rs);
			in_range(int'(rd), 6, 12);
		end
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0003);
		axi_write(rcdsw_pkg::OFF_SLEEP_CONTROL, 32'h0000_0001);
		repeat (20) @(posedge aclk);
		check({31'h0, radio_off_permitted}, 32'h0);
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0002);
		p = rcdsw_pkg::CLK_HZ / 32768;
		g = int'(rcdsw_pkg::SLOT_T_32K768) * rcdsw_pkg::CLK_HZ / 32768;
		do_sleep(rcdsw_pkg::LP_SEL_32K768, 10'hA, 10'h1, 10'h3, 32'd200, 2'h1);
		s0 = slot_n;
		wait (slot_n == s0 + 2);
		@(posedge aclk);
		in_range(slot_gap, g - 2, g + 2);
		e0 = exit_n;
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0003);
		for (int k = 0; k < 4 && !lp_wake_irq; k++) @(posedge aclk);
		check({31'h0, lp_wake_irq}, 32'h1);
		wait (!lp_wake_irq);
		@(posedge aclk);
		in_range(wake_w, p - 2, 2 * p + 4);
		wait (exit_n != e0);
		axi_read(rcdsw_pkg::OFF_SLEEP_ELAPSED, rd, rs);
		in_range(int'(rd), 1, 199);
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0002);
		do_sleep(rcdsw_pkg::LP_SEL_32K768, 10'h3, 10'h1, 10'h2, 32'h5, 2'h3);
		e0 = exit_n;
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0005);
		repeat (20) @(posedge aclk);
		check({31'h0, lp_wake_irq}, 32'h0);
		wait (lp_wake_irq);
		wait (!lp_wake_irq);
		axi_write(rcdsw_pkg::OFF_GENERAL_CTRL, 32'h0000_0002);
		wait (exit_n != e0);
		repeat (4) @(posedge aclk);
		check(exit_n, e0 + 1);
		give_verdict();
	end
endmodule : radio_core_deep_sleep_wakeup_tb
`default_nettype wire
